// [dv/sdu_monitor.sv]
`timescale 1ns/1ps
module sdu_monitor
  import sdu_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_ce,
  input wire logic        i_start,
  input wire logic        i_long_quotient_op,
  input wire logic [31:0] i_divisor,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic [63:0] o_dst,
  input wire logic        o_dst_we,
  input wire logic        o_flag_c,
  input wire logic        o_flag_z,
  input wire logic        o_flag_s,
  input wire logic        o_flag_v,
  input wire logic        i_reg_rd,
  input wire logic [31:0] o_reg_rdata
);
  logic go;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // a request is only taken when idle and enabled
  assign go = i_start && i_ce && !o_busy;

  // handshake: busy follows a taken start, done is a lone pulse that ends busy
  start_busy_a: assert property (go |=> o_busy) else $error("busy missing after start");
  done_pulse_a: assert property (o_done |-> !o_busy ##1 !o_done) else $error("done not one cycle");
  done_busy_a: assert property (o_done |-> $past(o_busy)) else $error("done without busy");
  // a write back never comes with plain overflow, which leaves the destination alone
  we_done_a: assert property (o_dst_we |-> o_done && !(o_flag_v && !o_flag_c))
    else $error("write strobe in wrong outcome");
  // zero divisor finishes early with its fixed flag pattern
  zero_word_a: assert property (go && !i_long_quotient_op && i_divisor[15:0] == 16'h0000
    |=> o_busy[*8] ##6 o_done && o_flag_v && !o_flag_c && !o_flag_s && o_flag_z && !o_dst_we)
    else $error("word zero divisor wrong");
  zero_long_a: assert property (go && i_long_quotient_op && i_divisor == 32'h00000000
    |-> ##31 o_done && o_flag_v && !o_flag_c && !o_flag_s && o_flag_z && !o_dst_we)
    else $error("long zero divisor wrong");
  margin_ovf_a: assert property (o_done && o_flag_c |-> o_flag_v) else $error("carry without overflow");
  // results only move on their strobes
  flags_hold_a: assert property (!o_done |-> $stable({o_flag_c, o_flag_z, o_flag_s, o_flag_v}))
    else $error("flags moved without done");
  dst_hold_a: assert property (!o_dst_we |-> $stable(o_dst)) else $error("destination moved");
  rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h00000000)
    else $error("read data outside read cycle");
endmodule

bind sdu_signed_divide_unit sdu_monitor u_sdu_monitor (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_start(i_start), .i_long_quotient_op(i_long_quotient_op), .i_divisor(i_divisor), .o_busy(o_busy),
  .o_done(o_done), .o_dst(o_dst), .o_dst_we(o_dst_we), .o_flag_c(o_flag_c), .o_flag_z(o_flag_z),
  .o_flag_s(o_flag_s), .o_flag_v(o_flag_v), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));

// [dv/sdu_seq_model.sv]
`timescale 1ns/1ps
module sdu_seq_model (
  input  wire logic        i_core_clk,
  input  wire logic [63:0] i_dst,
  input  wire logic        i_dst_we,
  output logic             o_start,
  output logic             o_long,
  output logic [63:0]      o_dividend,
  output logic [31:0]      o_divisor
);
  logic [63:0] dst_reg;
  logic [31:0] src_reg;

  // operands only mean something beside start; inverted otherwise so stale values never pass
  assign o_dividend = o_start ? dst_reg : ~dst_reg;
  assign o_divisor  = o_start ? src_reg : ~src_reg;

  // destination written back only on the strobe; the source storage is loaded by launch and never written back
  always @(posedge i_core_clk)
    if (i_dst_we)
      dst_reg <= i_dst;

  initial
  begin
    o_start = 1'b0;
    o_long  = 1'b0;
  end

  // one-cycle start with operands loaded into the register file
  task automatic launch(input logic [63:0] dst, input logic [31:0] src, input logic lng);
    @(posedge i_core_clk);
    dst_reg <= dst;
    src_reg <= src;
    o_long  <= lng;
    o_start <= 1'b1;
    @(posedge i_core_clk);
    o_start <= 1'b0;
  endtask
endmodule

// [dv/signed_divide_unit_tb.sv]
`timescale 1ns/1ps
module signed_divide_unit_tb;
  import sdu_pkg::*;
  logic        core_clk;
  logic        rst;
  logic        ce;
  logic        start;
  logic        lng;
  logic [63:0] dividend;
  logic [31:0] divisor;
  logic        busy;
  logic        done;
  logic [63:0] dst;
  logic        dst_we;
  logic        fc;
  logic        fz;
  logic        fs;
  logic        fv;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        irq;
  logic [31:0] d;
  int          err_total;
  int          comparisons;
  int          hold;

  sdu_signed_divide_unit u_sdu_signed_divide_unit (.i_core_clk(core_clk), .i_rst(rst), .i_ce(ce),
    .i_start(start), .i_long_quotient_op(lng), .i_dividend(dividend), .i_divisor(divisor), .o_busy(busy),
    .o_done(done), .o_dst(dst), .o_dst_we(dst_we), .o_flag_c(fc), .o_flag_z(fz), .o_flag_s(fs),
    .o_flag_v(fv), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .o_irq(irq));
  sdu_seq_model u_sdu_seq_model (.i_core_clk(core_clk), .i_dst(dst), .i_dst_we(dst_we), .o_start(start),
    .o_long(lng), .o_dividend(dividend), .o_divisor(divisor));

  // 40 MHz
  always #12.5 core_clk = ~core_clk;

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic reg_rd_t(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // one divide; flags as {v,c,z,s}; chk low skips the undefined destination and sign
  task automatic run(input logic [63:0] dd, input logic [31:0] sr, input logic lf, input logic [63:0] ed,
                     input logic [3:0] ef, input logic chk, input int unsigned ne);
    int n;
    u_sdu_seq_model.launch(dd, sr, lf);
    n = 0;
    do
    begin
      @(posedge core_clk);
      ce <= (n < 9 || n >= 9 + hold); // pause mid-run; frozen edges add to the count
      #1;
      n++;
    end while (done !== 1'b1 && n < 800);
    if (n >= 800)
    begin
      err_total++;
      final_report;
    end
    check("cycles", 64'(n), 64'(ne + hold));
    check("flags", {60'h0, {fv, fc, fz, fs} & {3'h7, chk}}, {60'h0, ef});
    @(posedge core_clk);
    #1;
    if (chk)
      check("dst", u_sdu_seq_model.dst_reg, ed);
    check("src", {32'h0, u_sdu_seq_model.src_reg}, {32'h0, sr});
  endtask

  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_total = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    reg_rd_t(MASK_OFS, d);
    check("mask", d, 32'h0);
    run(64'h22, 32'h6, 1'b0, 64'h0004_0005, 4'h0, 1'b1, WORD_CYCLES);
    reg_rd_t(STATUS_OFS, d);
    check("status", d, 32'h1);
    check("irq", irq, 1'b0);
    reg_wr_t(MASK_OFS, 32'hF);
    check("irq", irq, 1'b1);
    reg_wr_t(STATUS_OFS, 32'h1);
    check("irq", irq, 1'b0);
    run(64'hFFFF_FFF9, 32'h2, 1'b0, 64'hFFFF_FFFD, 4'h1, 1'b1, WORD_CYCLES);
    reg_rd_t(RESULT_OFS, d);
    check("result", d, 32'h4);
    run(64'h5, 32'h7, 1'b0, 64'h0005_0000, 4'h2, 1'b1, WORD_CYCLES);
    run(64'h1234_5678, 32'hFFFF_0000, 1'b0, 64'h1234_5678, 4'hA, 1'b1, WORD_CYCLES - WORD_ZERO_SAVE);
    run(64'h7FFF_FFFF, 32'h1, 1'b0, 64'h0, 4'h8, 1'b0, WORD_CYCLES - WORD_OVF_SAVE);
    run(64'h0001_0000, 32'h2, 1'b0, 64'h8000, 4'hC, 1'b1, WORD_CYCLES);
    run(64'hFFFE_FFFE, 32'h2, 1'b0, 64'h7FFF, 4'hD, 1'b1, WORD_CYCLES);
    reg_rd_t(STATUS_OFS, d);
    check("status", d & 32'hE, 32'hE);
    check("irq", irq, 1'b1);
    reg_wr_t(STATUS_OFS, 32'hF);
    reg_rd_t(STATUS_OFS, d);
    check("status", d, 32'h0);
    check("irq", irq, 1'b0);
    reg_wr_t(8'h40, 32'h0);
    reg_rd_t(8'h40, d);
    check("unmapped", d, 32'h0);
    reg_rd_t(MASK_OFS, d);
    check("mask", d, 32'hF);
    run(64'hFFFF_FFFF_FFFF_FF9C, 32'h7, 1'b1, 64'hFFFF_FFFE_FFFF_FFF2, 4'h1, 1'b1, LONG_CYCLES);
    run(64'h1_0000_0000, 32'h2, 1'b1, 64'h8000_0000, 4'hC, 1'b1, LONG_CYCLES);
    run(64'h55, 32'h0, 1'b1, 64'h55, 4'hA, 1'b1, LONG_CYCLES - LONG_ZERO_SAVE);
    run(64'h7FFF_FFFF_FFFF_FFFF, 32'h1, 1'b1, 64'h0, 4'h8, 1'b0, LONG_CYCLES - LONG_OVF_SAVE);
    // negative divisors, and the negative edge between marginal and gross overflow
    run(64'h5A5A_5A5A_0000_0007, 32'hABCD_FFFE, 1'b0, 64'h0001_FFFD, 4'h1, 1'b1, WORD_CYCLES);
    run(64'hFFFF_0000, 32'h1, 1'b0, 64'h0, 4'hD, 1'b1, WORD_CYCLES);
    run(64'hFFFE_FFFF, 32'h1, 1'b0, 64'h0, 4'h8, 1'b0, WORD_CYCLES - WORD_OVF_SAVE);
    hold = 5;
    run(64'h64, 32'hFFFF_FFF9, 1'b1, 64'h0000_0002_FFFF_FFF2, 4'h1, 1'b1, LONG_CYCLES);
    hold = 0;
    final_report;
  end
endmodule

// [pkg/sdu_core_if.sv]
`timescale 1ns/1ps
interface sdu_core_if;
  logic        start;
  logic [63:0] dividend_mag;
  logic [31:0] divisor_mag;
  logic [6:0]  steps;
  logic [63:0] quo_mag;
  logic [31:0] rem_mag;
  logic        busy;

  modport ctrl (output start, output dividend_mag, output divisor_mag, output steps,
                input quo_mag, input rem_mag, input busy);
  modport core (input start, input dividend_mag, input divisor_mag, input steps,
                output quo_mag, output rem_mag, output busy);
endinterface

// [pkg/sdu_pkg.sv]
package sdu_pkg;

  // operand widths
  localparam int unsigned DIVIDEND_W = 64;
  localparam int unsigned DIVISOR_W  = 32;
  localparam int unsigned WORD_BITS  = 16;
  localparam int unsigned LONG_BITS  = 32;

  // whole-instruction cycle counts and the early-finish savings
  localparam int unsigned WORD_CYCLES    = 107;
  localparam int unsigned LONG_CYCLES    = 744;
  localparam int unsigned WORD_ZERO_SAVE = 94;
  localparam int unsigned LONG_ZERO_SAVE = 714;
  localparam int unsigned WORD_OVF_SAVE  = 82;
  localparam int unsigned LONG_OVF_SAVE  = 693;
  localparam int unsigned CNT_W          = 10;

  localparam logic [CNT_W-1:0] WORD_FULL_CNT = CNT_W'(WORD_CYCLES);
  localparam logic [CNT_W-1:0] LONG_FULL_CNT = CNT_W'(LONG_CYCLES);
  localparam logic [CNT_W-1:0] WORD_ZERO_CNT = CNT_W'(WORD_CYCLES - WORD_ZERO_SAVE);
  localparam logic [CNT_W-1:0] LONG_ZERO_CNT = CNT_W'(LONG_CYCLES - LONG_ZERO_SAVE);
  localparam logic [CNT_W-1:0] WORD_OVF_CNT  = CNT_W'(WORD_CYCLES - WORD_OVF_SAVE);
  localparam logic [CNT_W-1:0] LONG_OVF_CNT  = CNT_W'(LONG_CYCLES - LONG_OVF_SAVE);

  // divider iteration counts (one quotient bit per cycle)
  localparam logic [6:0] WORD_STEPS = 7'h20;
  localparam logic [6:0] LONG_STEPS = 7'h40;

  // register port
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0] STATUS_OFS    = 8'h00;
  localparam logic [7:0] MASK_OFS      = 8'h04;
  localparam logic [7:0] RESULT_OFS    = 8'h08;

  // event bit positions, shared by status and mask
  localparam int unsigned EV_DONE   = 0;
  localparam int unsigned EV_ZERO   = 1;
  localparam int unsigned EV_GROSS  = 2;
  localparam int unsigned EV_MARGIN = 3;
  localparam int unsigned EV_W      = 4;
  localparam logic [3:0] EV_RESET   = 4'h0;

  // result register fields: c z s v busy
  localparam int unsigned RF_C    = 0;
  localparam int unsigned RF_Z    = 1;
  localparam int unsigned RF_S    = 2;
  localparam int unsigned RF_V    = 3;
  localparam int unsigned RF_BUSY = 4;

  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } sdu_state_t;

endpackage

// [rtl/sdu_mag_divider.sv]
`timescale 1ns/1ps
module sdu_mag_divider
  import sdu_pkg::*;
(
  input  wire logic  i_core_clk,
  input  wire logic  i_rst,
  input  wire logic  i_ce,
  sdu_core_if.core   bus
);

  logic [32:0] rem;
  logic [63:0] quo;
  logic [6:0]  left;
  logic [32:0] trial;
  logic        fits;

  // shift in the next dividend bit and try the subtraction
  always_comb
  begin
    trial = {rem[31:0], quo[63]};
    fits  = (trial >= {1'b0, bus.divisor_mag});
  end

  // restoring division on magnitudes, msb first; word operands are preloaded high
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      rem  <= 33'h0_0000_0000;
      quo  <= 64'h0;
      left <= 7'h00;
    end
    else if (i_ce)
    begin
      if (bus.start)
      begin
        rem  <= 33'h0_0000_0000;
        quo  <= (bus.steps == WORD_STEPS) ? {bus.dividend_mag[31:0], 32'h0000_0000} : bus.dividend_mag;
        left <= bus.steps;
      end
      else if (left != 7'h00)
      begin
        rem  <= fits ? (trial - {1'b0, bus.divisor_mag}) : trial;
        quo  <= {quo[62:0], fits};
        left <= left - 7'h01;
      end
    end
  end

  assign bus.quo_mag = (left == 7'h00 && bus.steps == WORD_STEPS) ? {32'h0000_0000, quo[31:0]} : quo;
  assign bus.rem_mag = rem[31:0];
  assign bus.busy    = (left != 7'h00);

endmodule

// [rtl/sdu_signed_divide_unit.sv]
// What this block does
// [RULE1] word form: 32-bit pair divided by 16 bits, quotient low half, remainder high
// [RULE2] long form: 64-bit quadruple divided by 32 bits, quotient low, remainder high
// [RULE3] divisor arrives as a value whatever its addressing mode; destination is a register
// [RULE4] divisor storage is never written by this unit
// [RULE5] dividend and divisor are signed two's complement
// [RULE6] remainder takes the dividend's sign; quotient truncates toward zero
// [RULE7] normal range: write results, clear overflow and carry, zero and sign from quotient
// [RULE8] zero divisor: destination unchanged, overflow set, carry and sign cleared
// [RULE9] gross overflow: destination undefined, overflow set, carry and zero cleared
// [RULE10] marginal overflow: store quotient without sign plus remainder, set overflow and carry
// [RULE11] zero flag set when quotient or divisor is zero, unless forced clear
// [RULE12] sign flag undefined on gross overflow, else follows quotient sign
// [RULE13] overflow set on zero divisor or quotient outside the normal range
// [RULE14] zero divisor and overflow finish early by the documented cycle savings
// [RULE15] start pulse with operands; busy until results valid; one-cycle done
`timescale 1ns/1ps
module sdu_signed_divide_unit
  import sdu_pkg::*;
(
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_ce,
  input  wire logic                         i_start,
  input  wire logic                         i_long_quotient_op,
  input  wire logic [sdu_pkg::DIVIDEND_W-1:0] i_dividend,
  input  wire logic [sdu_pkg::DIVISOR_W-1:0]  i_divisor,
  output logic                              o_busy,
  output logic                              o_done,
  output logic [sdu_pkg::DIVIDEND_W-1:0]    o_dst,
  output logic                              o_dst_we,
  output logic                              o_flag_c,
  output logic                              o_flag_z,
  output logic                              o_flag_s,
  output logic                              o_flag_v,
  input  wire logic [sdu_pkg::ADDR_W-1:0]   i_reg_addr,
  input  wire logic [31:0]                  i_reg_wdata,
  input  wire logic                         i_reg_wr,
  input  wire logic                         i_reg_rd,
  output logic [31:0]                       o_reg_rdata,
  output logic                              o_irq
);

  sdu_core_if core_bus ();

  sdu_state_t       state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] target;
  logic             op_long;
  logic             op_zero;
  logic             op_gross;
  logic             q_neg;
  logic             a_neg;
  logic [63:0]      a_mag;
  logic [31:0]      b_mag;
  logic             core_start;
  logic [6:0]       core_steps;
  logic [EV_W-1:0]  status;
  logic [EV_W-1:0]  mask;
  logic [EV_W-1:0]  next_status;
  logic [EV_W-1:0]  events;

  // operand preparation, looked at only in the start cycle
  logic             in_a_neg;
  logic             in_b_neg;
  logic [63:0]      in_a_sx;
  logic [31:0]      in_b_sx;
  logic [63:0]      in_a_mag;
  logic [31:0]      in_b_mag;
  logic             in_q_neg;
  logic             in_zero;
  logic [65:0]      in_limit;
  logic             in_gross;
  logic             take;

  assign take = (state == ST_IDLE) && i_start; // RULE15

  // sign-extend to full width and take magnitudes; the most negative value still fits unsigned
  always_comb
  begin
    in_a_neg = i_long_quotient_op ? i_dividend[63] : i_dividend[31]; // RULE5
    in_b_neg = i_long_quotient_op ? i_divisor[31] : i_divisor[15];
    in_a_sx  = i_long_quotient_op ? i_dividend : {{32{i_dividend[31]}}, i_dividend[31:0]}; // RULE1 RULE2
    in_b_sx  = i_long_quotient_op ? i_divisor : {{16{i_divisor[15]}}, i_divisor[15:0]}; // RULE3
    in_a_mag = in_a_neg ? (64'h0 - in_a_sx) : in_a_sx;
    in_b_mag = in_b_neg ? (32'h0000_0000 - in_b_sx) : in_b_sx;
    in_q_neg = in_a_neg ^ in_b_neg;
    in_zero  = (in_b_sx == 32'h0000_0000);
  end

  // gross overflow is |q| >= 2^n (positive) or |q| > 2^n (negative), known before dividing,
  // which is what lets the overflow case finish early
  always_comb
  begin
    in_limit = i_long_quotient_op ? ({34'h0_0000_0000, in_b_mag} << LONG_BITS)
                                  : ({34'h0_0000_0000, in_b_mag} << WORD_BITS);
    if (in_q_neg)
    begin
      in_limit = in_limit + {34'h0_0000_0000, in_b_mag};
    end
    in_gross = !in_zero && ({2'b00, in_a_mag} >= in_limit); // RULE9
  end

  // cycle budget per outcome
  logic [CNT_W-1:0] in_target;
  always_comb
  begin
    if (in_zero)
    begin
      in_target = i_long_quotient_op ? LONG_ZERO_CNT : WORD_ZERO_CNT; // RULE14
    end
    else if (in_gross)
    begin
      in_target = i_long_quotient_op ? LONG_OVF_CNT : WORD_OVF_CNT; // RULE14
    end
    else
    begin
      in_target = i_long_quotient_op ? LONG_FULL_CNT : WORD_FULL_CNT;
    end
  end

  // operand capture; the divider is skipped when the outcome is already known
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      op_long    <= 1'b0;
      op_zero    <= 1'b0;
      op_gross   <= 1'b0;
      q_neg      <= 1'b0;
      a_neg      <= 1'b0;
      a_mag      <= 64'h0;
      b_mag      <= 32'h0000_0000;
      target     <= {CNT_W{1'b0}};
      core_start <= 1'b0;
      core_steps <= WORD_STEPS;
    end
    else if (i_ce)
    begin
      core_start <= take && !in_zero && !in_gross;
      if (take)
      begin
        op_long    <= i_long_quotient_op;
        op_zero    <= in_zero;
        op_gross   <= in_gross;
        q_neg      <= in_q_neg;
        a_neg      <= in_a_neg;
        a_mag      <= in_a_mag;
        b_mag      <= in_b_mag;
        target     <= in_target;
        core_steps <= i_long_quotient_op ? LONG_STEPS : WORD_STEPS;
      end
    end
  end

  assign core_bus.start        = core_start;
  assign core_bus.dividend_mag = a_mag;
  assign core_bus.divisor_mag  = b_mag;
  assign core_bus.steps        = core_steps;

  sdu_mag_divider u_divider
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .bus        (core_bus.core)
  );

  // signed results from the magnitudes
  logic [63:0] q_signed;
  logic [31:0] r_signed;
  logic        q_is_zero;
  logic        q_normal;
  logic [63:0] half;
  always_comb
  begin
    q_signed  = q_neg ? (64'h0 - core_bus.quo_mag) : core_bus.quo_mag;
    r_signed  = a_neg ? (32'h0000_0000 - core_bus.rem_mag) : core_bus.rem_mag; // RULE6
    q_is_zero = (core_bus.quo_mag == 64'h0);
    half      = op_long ? 64'h0000_0000_8000_0000 : 64'h0000_0000_0000_8000;
    // negative side reaches one further than positive
    q_normal  = q_neg ? (core_bus.quo_mag <= half) : (core_bus.quo_mag < half); // RULE7 RULE13
  end

  // sequencing: count edges from the start edge; done lands on the budgeted edge
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state  <= ST_IDLE;
      cnt    <= {CNT_W{1'b0}};
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else if (i_ce)
    begin
      o_done <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          if (take)
          begin
            state  <= ST_RUN;
            cnt    <= {{(CNT_W-1){1'b0}}, 1'b1};
            o_busy <= 1'b1; // RULE15
          end
        end
        ST_RUN:
        begin
          if (cnt == target)
          begin
            state  <= ST_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1; // RULE15
          end
          else
          begin
            cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
      endcase
    end
  end

  logic finish;
  assign finish = (state == ST_RUN) && (cnt == target);

  // results and flags; only the destination is ever written, never the divisor
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_dst    <= 64'h0;
      o_dst_we <= 1'b0;
      o_flag_c <= 1'b0;
      o_flag_z <= 1'b0;
      o_flag_s <= 1'b0;
      o_flag_v <= 1'b0;
    end
    else if (i_ce)
    begin
      o_dst_we <= 1'b0;
      if (finish)
      begin
        if (op_zero)
        begin
          o_flag_v <= 1'b1; // RULE8 RULE13
          o_flag_c <= 1'b0; // RULE8
          o_flag_s <= 1'b0; // RULE8
          o_flag_z <= 1'b1; // RULE11
        end
        else if (op_gross)
        begin
          // sign is undefined here; driven low so the output stays deterministic
          o_flag_v <= 1'b1; // RULE9 RULE13
          o_flag_c <= 1'b0; // RULE9
          o_flag_z <= 1'b0; // RULE9 RULE11
          o_flag_s <= 1'b0; // RULE12
        end
        else
        begin
          // marginal case stores the low n quotient bits, which drops its sign bit
          o_dst    <= op_long ? {r_signed, q_signed[31:0]} // RULE2 RULE10
                              : {32'h0000_0000, r_signed[15:0], q_signed[15:0]}; // RULE1
          o_dst_we <= 1'b1; // RULE4
          o_flag_v <= !q_normal; // RULE7 RULE10 RULE13
          o_flag_c <= !q_normal; // RULE7 RULE10
          o_flag_z <= q_is_zero; // RULE11
          o_flag_s <= q_neg && !q_is_zero; // RULE12
        end
      end
    end
  end

  // events raised on the finishing edge
  always_comb
  begin
    events            = EV_RESET;
    events[EV_DONE]   = finish;
    events[EV_ZERO]   = finish && op_zero;
    events[EV_GROSS]  = finish && op_gross;
    events[EV_MARGIN] = finish && !op_zero && !op_gross && !q_normal;
  end

  // write-one-to-clear, with a same-cycle event winning over the clear
  always_comb
  begin
    next_status = status;
    if (i_reg_wr && i_reg_addr == STATUS_OFS)
    begin
      next_status = status & ~i_reg_wdata[EV_W-1:0];
    end
    next_status = next_status | events;
  end

  // status, mask and the interrupt level
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      status <= EV_RESET;
      mask   <= EV_RESET;
      o_irq  <= 1'b0;
    end
    else if (i_ce)
    begin
      status <= next_status;
      if (i_reg_wr && i_reg_addr == MASK_OFS)
      begin
        mask <= i_reg_wdata[EV_W-1:0];
      end
      o_irq <= |(next_status & ((i_reg_wr && i_reg_addr == MASK_OFS) ? i_reg_wdata[EV_W-1:0] : mask));
    end
  end

  // register reads: data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_reg_rdata <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      o_reg_rdata <= 32'h0000_0000;
      if (i_reg_rd)
      begin
        unique case (i_reg_addr)
          STATUS_OFS: o_reg_rdata <= {28'h000_0000, status};
          MASK_OFS:   o_reg_rdata <= {28'h000_0000, mask};
          RESULT_OFS: o_reg_rdata <= {27'h000_0000, o_busy, o_flag_v, o_flag_s, o_flag_z, o_flag_c};
          default:    o_reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
